// ### rtl/fsr_map.vh
`ifndef FSR_MAP_VH
`define FSR_MAP_VH

// software register offsets (byte addresses)
`define FSR_REG_CTRL      8'h00
`define FSR_REG_ADDR      8'h04
`define FSR_REG_WDATA     8'h08
`define FSR_REG_STATUS    8'h0c
`define FSR_REG_RDATA     8'h10
`define FSR_REG_RSTCMD    8'h14
`define FSR_REG_LAST      8'h18

// control register, write-one pulses
`define FSR_CTRL_WRITE    0
`define FSR_CTRL_POLL     1
`define FSR_CTRL_ADD      2
`define FSR_CTRL_READ     3

// status register fields
`define FSR_ST_BUSY       0
`define FSR_ST_DONE       1
`define FSR_ST_FAIL       2
`define FSR_ST_REJECT     3
`define FSR_ST_ERASING    4
`define FSR_ST_SUSPEND    5
`define FSR_ST_GAP_OK     6
`define FSR_ST_READY      7

// flash status bit positions
`define FSR_BIT_POLL      7
`define FSR_BIT_TGL1      6
`define FSR_BIT_TLIM      5
`define FSR_BIT_ETMR      3
`define FSR_BIT_TGL2      2

// reset values
`define FSR_RSTCMD_RST    8'hf0

// timing
`define FSR_CLK_NS        100
`define FSR_GAP_NS        50000
`define FSR_GAP_CYC       ((`FSR_GAP_NS) / (`FSR_CLK_NS))

`endif

// ### rtl/fsr_bus_cycle.v
`timescale 1ns/1ns
`default_nettype none

// one asynchronous flash bus cycle: strobe low for a fixed count, then a recovery cycle
module fsr_bus_cycle #(
  parameter AW      = 21,
  parameter DW      = 8,
  parameter STB_CYC = 2
) (
  input  wire          clk_sys,
  input  wire          rst,
  input  wire          start,
  input  wire          is_write,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg           done,
  output reg  [DW-1:0] rdata_r,
  output reg  [AW-1:0] flash_addr,
  output reg           flash_ce_n,
  output reg           flash_oe_n,
  output reg           flash_we_n,
  output reg  [DW-1:0] flash_dq_o,
  output reg           flash_dq_oe,
  input  wire [DW-1:0] flash_dq_i
);
  localparam S_IDLE = 2'd0;
  localparam S_STB  = 2'd1;
  localparam S_REC  = 2'd2;

  reg [1:0]  state_r;
  reg [7:0]  cnt_r;
  reg        wr_r;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r     <= S_IDLE;
      cnt_r       <= 8'h00;
      wr_r        <= 1'b0;
      done        <= 1'b0;
      rdata_r     <= {DW{1'b0}};
      flash_addr  <= {AW{1'b0}};
      flash_ce_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      flash_we_n  <= 1'b1;
      flash_dq_o  <= {DW{1'b0}};
      flash_dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start) begin
            wr_r        <= is_write;
            flash_addr  <= addr;
            flash_dq_o  <= wdata;
            flash_dq_oe <= is_write;
            flash_ce_n  <= 1'b0;
            flash_oe_n  <= is_write;
            flash_we_n  <= ~is_write;
            cnt_r       <= STB_CYC[7:0];
            state_r     <= S_STB;
          end
        end
        S_STB: begin
          if (cnt_r <= 8'h01) begin
            // the device latches data on the rising write strobe; data held one more cycle
            if (!wr_r) begin
              rdata_r <= flash_dq_i;
            end
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            state_r    <= S_REC;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        S_REC: begin
          flash_dq_oe <= 1'b0;
          done        <= 1'b1;
          state_r     <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule

`default_nettype wire

// ### rtl/fsr_host.v
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "fsr_map.vh"

module fsr_host #(
  parameter AW      = 21,
  parameter DW      = 8,
  parameter STB_CYC = 2,
  parameter GAP_CYC = `FSR_GAP_CYC
) (
  input  wire          clk_sys,
  input  wire          rst,
  input  wire [7:0]    sw_addr,
  input  wire [31:0]   sw_wdata,
  input  wire          sw_wr,
  input  wire          sw_rd,
  output reg  [31:0]   sw_rdata,
  output wire [AW-1:0] flash_addr,
  output wire          flash_ce_n,
  output wire          flash_oe_n,
  output wire          flash_we_n,
  output wire [DW-1:0] flash_dq_o,
  output wire          flash_dq_oe,
  input  wire [DW-1:0] flash_dq_i,
  input  wire          ready_busy_n
);
  localparam S_IDLE  = 4'd0;
  localparam S_WR    = 4'd1;
  localparam S_RD1   = 4'd2;
  localparam S_RD2   = 4'd3;
  localparam S_RD3   = 4'd4;
  localparam S_RD4   = 4'd5;
  localparam S_RSTW  = 4'd6;
  localparam S_PRE   = 4'd7;
  localparam S_ADDW  = 4'd8;
  localparam S_POST  = 4'd9;
  localparam S_ARR   = 4'd10;
  localparam S_WAIT  = 4'd11;

  reg [3:0]    state_r;
  reg [AW-1:0] addr_r;
  reg [DW-1:0] wdata_r;
  reg [DW-1:0] rstcmd_r;
  reg [DW-1:0] rdata_r;
  reg [DW-1:0] first_r;
  reg [DW-1:0] last_r;
  reg          busy_r;
  reg          done_r;
  reg          fail_r;
  reg          reject_r;
  reg          erasing_r;
  reg          suspend_r;
  reg [15:0]   gap_cnt_r;
  reg          cyc_start_r;
  reg          cyc_write_r;
  reg [AW-1:0] cyc_addr_r;
  reg [DW-1:0] cyc_wdata_r;

  wire          cyc_done;
  wire [DW-1:0] cyc_rdata;
  wire          gap_ok;

  fsr_bus_cycle #(
    .AW      (AW),
    .DW      (DW),
    .STB_CYC (STB_CYC)
  ) u_cyc (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .start       (cyc_start_r),
    .is_write    (cyc_write_r),
    .addr        (cyc_addr_r),
    .wdata       (cyc_wdata_r),
    .done        (cyc_done),
    .rdata_r     (cyc_rdata),
    .flash_addr  (flash_addr),
    .flash_ce_n  (flash_ce_n),
    .flash_oe_n  (flash_oe_n),
    .flash_we_n  (flash_we_n),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_oe (flash_dq_oe),
    .flash_dq_i  (flash_dq_i)
  );

  // a bit toggles when it differs between two consecutive status reads
  function toggled;
    input [DW-1:0] a;
    input [DW-1:0] b;
    input integer  pos;
    begin
      toggled = a[pos] ^ b[pos];
    end
  endfunction

  // software may skip the erase-timer check only inside this window
  assign gap_ok = (gap_cnt_r < GAP_CYC[15:0]);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r     <= S_IDLE;
      addr_r      <= {AW{1'b0}};
      wdata_r     <= {DW{1'b0}};
      rstcmd_r    <= `FSR_RSTCMD_RST;
      rdata_r     <= {DW{1'b0}};
      first_r     <= {DW{1'b0}};
      last_r      <= {DW{1'b0}};
      busy_r      <= 1'b0;
      done_r      <= 1'b0;
      fail_r      <= 1'b0;
      reject_r    <= 1'b0;
      erasing_r   <= 1'b0;
      suspend_r   <= 1'b0;
      gap_cnt_r   <= 16'hffff;
      cyc_start_r <= 1'b0;
      cyc_write_r <= 1'b0;
      cyc_addr_r  <= {AW{1'b0}};
      cyc_wdata_r <= {DW{1'b0}};
    end else begin
      cyc_start_r <= 1'b0;
      if (gap_cnt_r != 16'hffff) begin
        gap_cnt_r <= gap_cnt_r + 16'h0001;
      end
      if (sw_wr && state_r == S_IDLE) begin
        case (sw_addr)
          `FSR_REG_ADDR:   addr_r   <= sw_wdata[AW-1:0];
          `FSR_REG_WDATA:  wdata_r  <= sw_wdata[DW-1:0];
          `FSR_REG_RSTCMD: rstcmd_r <= sw_wdata[DW-1:0];
          default: ;
        endcase
      end
      case (state_r)
        S_IDLE: begin
          if (sw_wr && sw_addr == `FSR_REG_CTRL) begin
            // done, fail and reject of the previous operation are cleared as the next one starts
            busy_r   <= 1'b1;
            done_r   <= 1'b0;
            fail_r   <= 1'b0;
            reject_r <= 1'b0;
            // status reads always use the software address: programmed or erasing sector
            cyc_addr_r  <= addr_r;
            cyc_wdata_r <= wdata_r;
            cyc_start_r <= 1'b1;
            if (sw_wdata[`FSR_CTRL_WRITE]) begin
              cyc_write_r <= 1'b1;
              state_r     <= S_WR;
            end else if (sw_wdata[`FSR_CTRL_POLL]) begin
              cyc_write_r <= 1'b0;
              state_r     <= S_RD1;
            end else if (sw_wdata[`FSR_CTRL_ADD]) begin
              cyc_write_r <= 1'b0;
              state_r     <= S_PRE;
            end else if (sw_wdata[`FSR_CTRL_READ]) begin
              cyc_write_r <= 1'b0;
              state_r     <= S_ARR;
            end else begin
              cyc_start_r <= 1'b0;
              busy_r      <= 1'b0;
            end
          end
        end
        S_WR: begin
          if (cyc_done) begin
            busy_r  <= 1'b0;
            done_r  <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_ARR: begin
          if (cyc_done) begin
            rdata_r <= cyc_rdata;
            busy_r  <= 1'b0;
            done_r  <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_RD1, S_RD3: begin
          if (cyc_done) begin
            first_r     <= cyc_rdata;
            cyc_start_r <= 1'b1;
            state_r     <= (state_r == S_RD1) ? S_RD2 : S_RD4;
          end
        end
        S_RD2: begin
          if (cyc_done) begin
            last_r  <= cyc_rdata;
            rdata_r <= cyc_rdata;
            if (!toggled(first_r, cyc_rdata, `FSR_BIT_TGL1)) begin
              // toggle one still: operation over, or erase suspended
              // a status-then-array pair can mimic suspend, so both reads need polling 1
              suspend_r <= toggled(first_r, cyc_rdata, `FSR_BIT_TGL2) &
                           first_r[`FSR_BIT_POLL] & cyc_rdata[`FSR_BIT_POLL];
              erasing_r <= 1'b0;
              busy_r    <= 1'b0;
              done_r    <= 1'b1;
              state_r   <= S_IDLE;
            end else begin
              suspend_r <= 1'b0;
              // erasing when erase-timer set and polling bit low
              erasing_r <= cyc_rdata[`FSR_BIT_ETMR] &
                           ~cyc_rdata[`FSR_BIT_POLL];
              cyc_start_r <= 1'b1;
              // limit flag seen: recheck, the toggling may stop just as it rises
              state_r <= cyc_rdata[`FSR_BIT_TLIM] ? S_RD3 : S_RD1;
            end
          end
        end
        S_RD4: begin
          if (cyc_done) begin
            last_r  <= cyc_rdata;
            rdata_r <= cyc_rdata;
            if (toggled(first_r, cyc_rdata, `FSR_BIT_TGL1)) begin
              // still toggling with limit flag high: failed, the device waits for reset
              fail_r      <= 1'b1;
              cyc_write_r <= 1'b1;
              cyc_wdata_r <= rstcmd_r;
              cyc_start_r <= 1'b1;
              state_r     <= S_RSTW;
            end else begin
              erasing_r <= 1'b0;
              busy_r    <= 1'b0;
              done_r    <= 1'b1;
              state_r   <= S_IDLE;
            end
          end
        end
        S_RSTW: begin
          if (cyc_done) begin
            erasing_r <= 1'b0;
            busy_r    <= 1'b0;
            done_r    <= 1'b1;
            state_r   <= S_IDLE;
          end
        end
        S_PRE: begin
          if (cyc_done) begin
            first_r <= cyc_rdata;
            if (cyc_rdata[`FSR_BIT_ETMR]) begin
              // window already closed: the device would ignore another sector
              reject_r  <= 1'b1;
              erasing_r <= 1'b1;
              busy_r    <= 1'b0;
              done_r    <= 1'b1;
              state_r   <= S_IDLE;
            end else begin
              cyc_write_r <= 1'b1;
              cyc_start_r <= 1'b1;
              state_r     <= S_ADDW;
            end
          end
        end
        S_ADDW: begin
          if (cyc_done) begin
            // each added sector restarts the device's window and our gap count
            gap_cnt_r   <= 16'h0000;
            cyc_write_r <= 1'b0;
            cyc_start_r <= 1'b1;
            state_r     <= S_POST;
          end
        end
        S_POST: begin
          if (cyc_done) begin
            last_r    <= cyc_rdata;
            rdata_r   <= cyc_rdata;
            // high on the second check: the last sector may not have been taken
            reject_r  <= cyc_rdata[`FSR_BIT_ETMR];
            erasing_r <= cyc_rdata[`FSR_BIT_ETMR];
            busy_r    <= 1'b0;
            done_r    <= 1'b1;
            state_r   <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sw_rdata <= 32'h0000_0000;
    end else if (sw_rd) begin
      case (sw_addr)
        `FSR_REG_ADDR:   sw_rdata <= {{(32-AW){1'b0}}, addr_r};
        `FSR_REG_WDATA:  sw_rdata <= {{(32-DW){1'b0}}, wdata_r};
        `FSR_REG_STATUS: sw_rdata <= {24'h000000, ready_busy_n, gap_ok, suspend_r,
                                      erasing_r, reject_r, fail_r, done_r, busy_r};
        `FSR_REG_RDATA:  sw_rdata <= {{(32-DW){1'b0}}, rdata_r};
        `FSR_REG_RSTCMD: sw_rdata <= {{(32-DW){1'b0}}, rstcmd_r};
        `FSR_REG_LAST:   sw_rdata <= {{(32-DW){1'b0}}, first_r};
        default:         sw_rdata <= 32'h0000_0000;
      endcase
    end else begin
      sw_rdata <= 32'h0000_0000;
    end
  end
endmodule

`default_nettype wire

// ### bench/fsr_host_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "fsr_map.vh"
module fsr_host_chk #(
  parameter int AW      = 21,
  parameter int DW      = 8,
  parameter int STB_CYC = 2
) (
  input wire logic          clk_sys,
  input wire logic          rst,
  input wire logic [7:0]    sw_addr,
  input wire logic [31:0]   sw_wdata,
  input wire logic          sw_wr,
  input wire logic          sw_rd,
  input wire logic [31:0]   sw_rdata,
  input wire logic [AW-1:0] flash_addr,
  input wire logic          flash_ce_n,
  input wire logic          flash_oe_n,
  input wire logic          flash_we_n,
  input wire logic [DW-1:0] flash_dq_o,
  input wire logic          flash_dq_oe,
  input wire logic [DW-1:0] flash_dq_i,
  input wire logic          ready_busy_n
);
  logic [AW-1:0] addr_sh_r;
  logic [7:0]    low_cnt_r;
  wire           stb = !flash_oe_n || !flash_we_n;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // address shadow is only meaningful while software writes ADDR when idle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_sh_r <= '0;
      low_cnt_r <= 8'h00;
    end else begin
      if (sw_wr && sw_addr == `FSR_REG_ADDR) addr_sh_r <= sw_wdata[AW-1:0];
      low_cnt_r <= stb ? low_cnt_r + 8'h01 : 8'h00;
    end
  end
  rd_idle_zero_a: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  unmapped_zero_a: assert property ($past(sw_rd) && $past(sw_addr) > `FSR_REG_LAST |-> sw_rdata == 32'h0)
    else $error("unmapped read not zero");
  strobe_excl_a: assert property (!(!flash_oe_n && !flash_we_n))
    else $error("read and write strobes low together");
  strobe_len_a: assert property ($fell(stb) |-> low_cnt_r == STB_CYC)
    else $error("strobe low length wrong");
  write_drive_a: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
    else $error("write strobe without select or drive");
  read_release_a: assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe)
    else $error("read strobe while driving data");
  cycle_hold_a: assert property (!flash_ce_n && $past(flash_ce_n) == 1'b0 |-> $stable(flash_addr) && $stable(flash_dq_o))
    else $error("address or data moved inside a cycle");
  status_addr_a: assert property ($fell(flash_ce_n) |-> flash_addr == addr_sh_r)
    else $error("flash cycle not at programmed address");
  cover property ($fell(flash_we_n));
  cover property ($fell(flash_oe_n));
  cover property (sw_rd && sw_addr == `FSR_REG_STATUS);
endmodule
bind fsr_host fsr_host_chk #(.AW(AW), .DW(DW), .STB_CYC(STB_CYC)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
  .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_o(flash_dq_o),
  .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i), .ready_busy_n(ready_busy_n));
`default_nettype wire

// ### bench/fsr_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fsr_flash_model #(
  parameter int WIN = 10000,
  parameter int PRG = 4000,
  parameter int ERS = 40000
) (
  input  wire logic [20:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  dq_h,
  output logic      [7:0]  dq,
  output logic             ready_busy_n
);
  // modes: 0 array, 1 program, 2 erase window, 3 erasing, 4 suspended, 5 failed
  int          md = 0, rm = 0;
  logic        arm = 1'b0, chip = 1'b0, t1 = 1'b0, t2 = 1'b0;
  logic [31:0] esec = '0;
  logic [7:0]  pd, mem [logic [20:0]];
  logic [20:0] pa;
  time         tend = 0;
  function automatic logic [7:0] arr(input logic [20:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  assign ready_busy_n = !(md inside {1, 2, 3, 5});
  initial dq = 8'h00;
  // sampled 1 ns after the strobe edge, when the host's registered outputs have settled
  always @(negedge we_n) begin
    #1;
    if (!ce_n && arm) begin
      arm = 1'b0;
      pd = dq_h;
      pa = addr;
      rm = md;
      md = 1;
      tend = $time + PRG;
    end else if (!ce_n) begin
      case (dq_h)
        8'ha0: arm = (md == 0 || md == 4);
        8'h30: if (md == 0 || md == 2) begin
          esec[addr[20:16]] = 1'b1;
          md = 2;
          tend = $time + WIN;
        end else if (md == 4) begin
          md = 3;
          tend = $time + ERS;
        end
        8'h10: if (md == 0) begin
          chip = 1'b1;
          md = 3;
          tend = $time + ERS;
        end
        8'hb0: if (md == 3) md = 4;
        8'hf0: if (md == 5) md = 0;
        default: ;
      endcase
    end
  end
  always #100 if (md inside {1, 2, 3} && $time >= tend) begin
    if (md == 2) begin
      md = 3;
      tend = $time + ERS;
    end else if (md == 1 && (pd & ~arr(pa)) != 8'h00) md = 5;
    else if (md == 1) begin
      // a program made under suspend drops back into the suspended erase
      mem[pa] = pd;
      md = rm;
    end else begin
      foreach (mem[k]) if (chip || esec[k[20:16]]) mem[k] = 8'hff;
      md = 0;
      chip = 1'b0;
      esec = '0;
    end
  end
  always @(negedge oe_n) begin
    #1;
    if (!ce_n) begin
      if (md inside {1, 2, 3, 5}) t1 = ~t1;
      if (md inside {2, 3, 4} && (esec[addr[20:16]] | chip)) t2 = ~t2;
      case (md)
        1, 5: dq = {~pd[7], t1, md == 5, 5'h00};
        2, 3: dq = {1'b0, t1, 2'b00, md == 3, t2, 2'b00};
        4: dq = esec[addr[20:16]] ? {1'b1, t1, 3'b000, t2, 2'b00} : arr(addr);
        default: dq = arr(addr);
      endcase
    end
  end
  // a released bus must not keep showing the last value
  always @(posedge oe_n) dq = ~dq;
endmodule
`default_nettype wire

// ### bench/test_flash_write_status_reporting.sv
`timescale 1ns/1ns
`default_nettype none
`include "fsr_map.vh"
module test_flash_write_status_reporting;
  localparam logic [20:0] SA = 21'h012345;
  localparam logic [20:0] SB = 21'h1f0000;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  wire  [31:0] sw_rdata;
  wire  [20:0] f_addr;
  wire         f_ce_n, f_oe_n, f_we_n, f_oe, rb_n;
  wire  [7:0]  f_do, m_dq;
  wire  [7:0]  dq_w = f_oe ? f_do : m_dq;
  int          n_mismatch = 0;
  int          n_checks = 0;
  logic [7:0]  v, r;
  logic [7:0]  exp_mem [logic [20:0]];
  fsr_host #(.GAP_CYC(20)) dut (.clk_sys(clk_sys), .rst(rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .flash_addr(f_addr), .flash_ce_n(f_ce_n), .flash_oe_n(f_oe_n), .flash_we_n(f_we_n),
    .flash_dq_o(f_do), .flash_dq_oe(f_oe), .flash_dq_i(dq_w), .ready_busy_n(rb_n));
  fsr_flash_model u_flash (.addr(f_addr), .ce_n(f_ce_n), .oe_n(f_oe_n), .we_n(f_we_n),
    .dq_h(dq_w), .dq(m_dq), .ready_busy_n(rb_n));
  initial forever #50 clk_sys = ~clk_sys;
  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    n_checks++;
    if ((got & m) !== (exp & m)) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h mask %h", $time, got, exp, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1 d = sw_rdata[7:0];
  endtask
  task automatic op(input logic [7:0] ctl, input logic [7:0] d);
    wr(`FSR_REG_WDATA, {24'h0, d});
    wr(`FSR_REG_CTRL, {24'h0, ctl});
    for (int i = 0; i < 3000; i++) begin
      rd(`FSR_REG_STATUS, r);
      if (r[0] === 1'b0) return;
    end
    n_mismatch++;
    $display("CHECK FAILED t=%0t busy too long", $time);
    wrap_up();
  endtask
  task automatic rd_arr(input logic [20:0] a);
    wr(`FSR_REG_ADDR, {11'h0, a});
    op(8'h08, 8'h00);
    rd(`FSR_REG_RDATA, r);
    chk(r, exp_mem.exists(a) ? exp_mem[a] : 8'hff, 8'hff);
  endtask
  initial begin
    r = 8'($urandom(82029));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`FSR_REG_RSTCMD, r);
    chk(r, 8'hf0, 8'hff);
    rd(8'h1c, r);
    chk(r, 8'h00, 8'hff);
    rd(`FSR_REG_STATUS, r);
    chk(r, 8'h80, 8'hff);
    wr(`FSR_REG_ADDR, {11'h0, SA});
    v = 8'($urandom) & 8'h7f;
    op(8'h01, 8'ha0);
    op(8'h01, v);
    rd(`FSR_REG_STATUS, r);
    chk(r, 8'h02, 8'h82);
    op(8'h02, 8'h00);
    chk(r, 8'h82, 8'haf);
    exp_mem[SA] = v;
    rd_arr(SA);
    op(8'h01, 8'ha0);
    op(8'h01, 8'hff);
    op(8'h02, 8'h00);
    chk(r, 8'h86, 8'haf);
    rd_arr(SA);
    op(8'h01, 8'h30);
    repeat (30) @(posedge clk_sys);
    op(8'h04, 8'h30);
    chk(r, 8'h42, 8'h5e);
    repeat (60) @(posedge clk_sys);
    op(8'h04, 8'h30);
    chk(r, 8'h42, 8'h5e);
    repeat (150) @(posedge clk_sys);
    op(8'h04, 8'h30);
    chk(r, 8'h1a, 8'h5e);
    op(8'h01, 8'hb0);
    op(8'h02, 8'h00);
    chk(r, 8'ha2, 8'hae);
    rd(`FSR_REG_LAST, r);
    chk(r, 8'h80, 8'ha0);
    rd_arr(SB);
    v = 8'($urandom);
    op(8'h01, 8'ha0);
    op(8'h01, v);
    rd(`FSR_REG_STATUS, r);
    chk(r, 8'h02, 8'h82);
    op(8'h02, 8'h00);
    exp_mem[SB] = v;
    rd_arr(SB);
    wr(`FSR_REG_ADDR, {11'h0, SA});
    op(8'h01, 8'h30);
    op(8'h02, 8'h00);
    chk(r, 8'h82, 8'haf);
    exp_mem.delete(SA);
    rd_arr(SA);
    op(8'h01, 8'h10);
    op(8'h04, 8'h30);
    chk(r, 8'h1a, 8'h5e);
    op(8'h02, 8'h00);
    exp_mem.delete();
    rd_arr(SA);
    rd_arr(SB);
    wrap_up();
  end
endmodule
`default_nettype wire
